// file: common/tec_pkg.sv
package tec_pkg;

   // ==========================================================
   // Widths
   localparam int TEC_AW = 8;
   localparam int TEC_DW = 8;
   localparam int TEC_CW = 16;
   localparam int TEC_PW = 9;

   // ==========================================================
   // Byte offsets
   localparam logic [7:0] OFS_CMP_A_LO = 8'h30;
   localparam logic [7:0] OFS_CMP_A_HI = 8'h31;
   localparam logic [7:0] OFS_CMP_B_LO = 8'h32;
   localparam logic [7:0] OFS_CMP_B_HI = 8'h33;
   localparam logic [7:0] OFS_MODE     = 8'h38;
   localparam logic [7:0] OFS_CTRL     = 8'h39;
   localparam logic [7:0] OFS_RUN      = 8'h3a;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h3b;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;
   localparam logic [7:0] OFS_CNT_LO   = 8'h3d;
   localparam logic [7:0] OFS_CNT_HI   = 8'h3e;

   // ==========================================================
   // Field positions
   localparam int MODE_CLK_LSB  = 0;
   localparam int MODE_CLR_EN   = 5;
   localparam int CTRL_BUF_EN   = 7;
   localparam int RUN_BIT       = 0;
   localparam int IRQ_A_BIT     = 0;
   localparam int IRQ_B_BIT     = 1;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  RST_MODE = 8'h00;
   localparam logic [7:0]  RST_CTRL = 8'h00;
   localparam logic [7:0]  RST_RUN  = 8'h00;
   localparam logic [1:0]  RST_IRQ  = 2'h0;
   localparam logic [15:0] RST_CMP  = 16'h0000;
   localparam logic [15:0] RST_CNT  = 16'h0000;

   // ==========================================================
   // Prescaler tap masks: tick when low bits all ones
   localparam logic [8:0] TAP_DIV8   = 9'h007;
   localparam logic [8:0] TAP_DIV32  = 9'h01f;
   localparam logic [8:0] TAP_DIV128 = 9'h07f;

   typedef enum logic [1:0] {
      TEC_CLK_EXT    = 2'b00,
      TEC_CLK_DIV8   = 2'b01,
      TEC_CLK_DIV32  = 2'b10,
      TEC_CLK_DIV128 = 2'b11
   } tec_clk_sel_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [TEC_AW-1:0] addr;
      logic [TEC_DW-1:0] wdata;
   } tec_bus_req_t;

   typedef struct packed {
      logic div128;
      logic div32;
      logic div8;
   } tec_ticks_t;

endpackage : tec_pkg

// file: design/tec_prescaler.sv
module tec_prescaler (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst,
   output tec_pkg::tec_ticks_t     o_ticks
);
   import tec_pkg::*;

   logic [TEC_PW-1:0] cnt;
   logic [TEC_PW-1:0] next_cnt;
   tec_ticks_t        next_ticks;

   // ==========================================================
   // Free running shared prescaler
   always_comb begin
      next_cnt          = cnt + 9'h001;
      next_ticks.div8   = ((cnt & TAP_DIV8) == TAP_DIV8);
      next_ticks.div32  = ((cnt & TAP_DIV32) == TAP_DIV32);
      next_ticks.div128 = ((cnt & TAP_DIV128) == TAP_DIV128);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt     <= '0;
         o_ticks <= '0;
      end else begin
         cnt     <= next_cnt;
         o_ticks <= next_ticks;
      end
   end

endmodule // tec_prescaler

// file: design/tec_edge_sync.sv
module tec_edge_sync (
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output logic      o_rise
);
   import tec_pkg::*;

   logic meta;
   logic sync;
   logic prev;
   logic next_rise;

   // ==========================================================
   // Only the second stage and later feed the edge detect
   always_comb begin
      next_rise = sync & ~prev;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         meta   <= 1'b0;
         sync   <= 1'b0;
         prev   <= 1'b0;
         o_rise <= 1'b0;
      end else begin
         meta   <= i_pin;
         sync   <= meta;
         prev   <= sync;
         o_rise <= next_rise;
      end
   end

endmodule // tec_edge_sync

// file: design/tec_timer.sv
// Overview of operation
// RULE1 - Sixteen bit up-counter steps once per tick of the chosen source.
// RULE2 - Source is the count pin or prescaler taps fc/8, fc/32, fc/128.
// RULE3 - Reset sets clock select to 00, choosing the count pin.
// RULE4 - Run bit set counts; run bit clear stops and zeroes the counter.
// RULE5 - With clear enable set, counter returns to zero on compare B match.
// RULE6 - With clear enable clear, counter free-runs and wraps.
// RULE7 - Each compare register raises a match when counter equals it.
// RULE8 - Software writes low byte before high byte of each compare value.
// RULE9 - Compare A and its buffer share byte offsets 30h low, 31h high.
// RULE10 - Buffer enable 0 disables, 1 enables double buffering of compare A.
// RULE11 - Buffered value moves into compare A on a compare B match.
// RULE12 - Reset clears buffer enable.
// RULE13 - Software writes initial value, sets buffer enable, then next value.
// RULE14 - Each comparator raises its own interrupt request on match.
// RULE15 - With the pin selected, counter advances on each rising pin edge.
// RULE16 - Clear enable written 0 suppresses clearing on compare B match.
// RULE17 - Unbuffered compare A writes take effect on the next comparison.
// RULE18 - Count pin is synchronised and edge detected before use.
module tec_timer (
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_rst,
   input  tec_pkg::tec_bus_req_t            i_bus,
   input  wire logic                        i_ext_count,
   output logic [tec_pkg::TEC_DW-1:0]       o_rdata,
   output logic [tec_pkg::TEC_CW-1:0]       o_count,
   output logic                             o_match_a,
   output logic                             o_match_b,
   output logic                             o_irq
);
   import tec_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic hit(input tec_bus_req_t b, input logic [7:0] ofs);
      hit = (b.addr == ofs);
   endfunction

   // ==========================================================
   // Clock sources
   tec_ticks_t ticks;
   logic       ext_rise;

   tec_prescaler u_presc (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .o_ticks   (ticks)
   );

   // RULE18 sync and edge
   tec_edge_sync u_ext (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_pin     (i_ext_count),
      .o_rise    (ext_rise)
   );

   // ==========================================================
   // Control registers
   logic [7:0] mode_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] run_reg;
   logic [1:0] irq_mask;
   logic [7:0] next_mode_reg;
   logic [7:0] next_ctrl_reg;
   logic [7:0] next_run_reg;
   logic [1:0] next_irq_mask;

   tec_clk_sel_t clk_sel;
   logic         clr_en;
   logic         buf_en;
   logic         run;

   assign clk_sel = tec_clk_sel_t'(mode_reg[MODE_CLK_LSB +: 2]);
   assign clr_en  = mode_reg[MODE_CLR_EN];
   assign buf_en  = ctrl_reg[CTRL_BUF_EN];
   assign run     = run_reg[RUN_BIT];

   always_comb begin
      next_mode_reg = mode_reg;
      next_ctrl_reg = ctrl_reg;
      next_run_reg  = run_reg;
      next_irq_mask = irq_mask;
      if (i_bus.wr) begin
         if (hit(i_bus, OFS_MODE)) begin
            next_mode_reg = i_bus.wdata;
         end
         if (hit(i_bus, OFS_CTRL)) begin
            next_ctrl_reg = i_bus.wdata;
         end
         if (hit(i_bus, OFS_RUN)) begin
            next_run_reg = i_bus.wdata;
         end
         if (hit(i_bus, OFS_IRQ_MASK)) begin
            next_irq_mask = i_bus.wdata[1:0];
         end
      end
   end

   // RULE3 RULE12 reset values
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mode_reg <= RST_MODE;
         ctrl_reg <= RST_CTRL;
         run_reg  <= RST_RUN;
         irq_mask <= RST_IRQ;
      end else begin
         mode_reg <= next_mode_reg;
         ctrl_reg <= next_ctrl_reg;
         run_reg  <= next_run_reg;
         irq_mask <= next_irq_mask;
      end
   end

   // ==========================================================
   // Tick selection
   logic tick;

   // RULE2 RULE15 source mux
   always_comb begin
      case (clk_sel)
         TEC_CLK_EXT:    tick = ext_rise;
         TEC_CLK_DIV8:   tick = ticks.div8;
         TEC_CLK_DIV32:  tick = ticks.div32;
         TEC_CLK_DIV128: tick = ticks.div128;
         default:        tick = 1'b0;
      endcase
   end

   // ==========================================================
   // Counter, compare registers and match detect
   logic [15:0] cnt;
   logic [15:0] cmp_a;
   logic [15:0] cmp_b;
   logic [15:0] buf_a;
   logic [7:0]  low_a;
   logic [7:0]  low_b;
   logic [15:0] next_cnt;
   logic [15:0] next_cmp_a;
   logic [15:0] next_cmp_b;
   logic [15:0] next_buf_a;
   logic [7:0]  next_low_a;
   logic [7:0]  next_low_b;
   logic        next_match_a;
   logic        next_match_b;

   always_comb begin
      next_cnt     = cnt;
      next_cmp_a   = cmp_a;
      next_cmp_b   = cmp_b;
      next_buf_a   = buf_a;
      next_low_a   = low_a;
      next_low_b   = low_b;
      // RULE7 RULE14 match detect
      next_match_a = run && tick && (cnt == cmp_a);
      next_match_b = run && tick && (cnt == cmp_b);

      // RULE4 stop clears counter
      if (!run) begin
         next_cnt = RST_CNT;
      end else if (tick) begin
         // RULE5 RULE6 RULE16 clear or wrap
         if (clr_en && (cnt == cmp_b)) begin
            next_cnt = RST_CNT;
         end else begin
            // RULE1 count up
            next_cnt = cnt + 16'h0001;
         end
      end

      // RULE11 reload on compare B match
      if (buf_en && next_match_b) begin
         next_cmp_a = buf_a;
      end

      // RULE8 low byte staged, high byte commits the word
      if (i_bus.wr) begin
         // RULE9 shared offsets
         if (hit(i_bus, OFS_CMP_A_LO)) begin
            next_low_a = i_bus.wdata;
         end
         if (hit(i_bus, OFS_CMP_A_HI)) begin
            next_buf_a = {i_bus.wdata, low_a};
            // RULE10 RULE17 unbuffered write goes straight in
            if (!buf_en) begin
               next_cmp_a = {i_bus.wdata, low_a};
            end
         end
         if (hit(i_bus, OFS_CMP_B_LO)) begin
            next_low_b = i_bus.wdata;
         end
         if (hit(i_bus, OFS_CMP_B_HI)) begin
            next_cmp_b = {i_bus.wdata, low_b};
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt       <= RST_CNT;
         cmp_a     <= RST_CMP;
         cmp_b     <= RST_CMP;
         buf_a     <= RST_CMP;
         low_a     <= '0;
         low_b     <= '0;
         o_match_a <= 1'b0;
         o_match_b <= 1'b0;
      end else begin
         cnt       <= next_cnt;
         cmp_a     <= next_cmp_a;
         cmp_b     <= next_cmp_b;
         buf_a     <= next_buf_a;
         low_a     <= next_low_a;
         low_b     <= next_low_b;
         o_match_a <= next_match_a;
         o_match_b <= next_match_b;
      end
   end

   assign o_count = cnt;

   // ==========================================================
   // Interrupt status, write one to clear, set wins
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] set_vec;
   logic       next_irq;

   always_comb begin
      set_vec            = '0;
      set_vec[IRQ_A_BIT] = next_match_a;
      set_vec[IRQ_B_BIT] = next_match_b;
      next_irq_stat      = irq_stat;
      if (i_bus.wr && hit(i_bus, OFS_IRQ_STAT)) begin
         next_irq_stat = irq_stat & ~i_bus.wdata[1:0];
      end
      // RULE14 sticky requests
      next_irq_stat = next_irq_stat | set_vec;
      next_irq      = |(next_irq_stat & irq_mask);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         irq_stat <= RST_IRQ;
         o_irq    <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         o_irq    <= next_irq;
      end
   end

   // ==========================================================
   // Read port; compare registers are write only and read zero
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (i_bus.rd) begin
         case (i_bus.addr)
            OFS_MODE:     next_rdata = mode_reg;
            OFS_CTRL:     next_rdata = ctrl_reg;
            OFS_RUN:      next_rdata = run_reg;
            OFS_IRQ_STAT: next_rdata = {6'h00, irq_stat};
            OFS_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            OFS_CNT_LO:   next_rdata = cnt[7:0];
            OFS_CNT_HI:   next_rdata = cnt[15:8];
            default:      next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= next_rdata;
      end
   end

endmodule // tec_timer

// file: verif/tec_pulse_src.sv
module tec_pulse_src (
   input  wire logic i_clk_sys,
   output logic      o_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_pin = 1'b0;

   // ==========================================================
   // Event source
   // Pin moves just after an edge; the two sync stages absorb it
   // rising edges
   task automatic pulses(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge i_clk_sys);
         o_pin <= 1'b1;
         repeat (half) @(posedge i_clk_sys);
         o_pin <= 1'b0;
      end
   endtask
endmodule // tec_pulse_src

// file: verif/tec_timer_asserts.sv
module tec_timer_asserts (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  tec_pkg::tec_bus_req_t      i_bus,
   input  wire logic                  i_ext_count,
   input  wire logic [7:0]            o_rdata,
   input  wire logic [15:0]           o_count,
   input  wire logic                  o_match_a,
   input  wire logic                  o_match_b,
   input  wire logic                  o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import tec_pkg::*;

   // ==========================================================
   // Shadow of control bits, seen from the bus
   logic [1:0] sel;
   logic       clr;
   logic       run;
   logic [1:0] mask;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sel <= 2'h0;
         clr <= 1'b0;
         run <= 1'b0;
         mask <= 2'h0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == OFS_MODE) begin
            sel <= i_bus.wdata[1:0];
            clr <= i_bus.wdata[MODE_CLR_EN];
         end
         if (i_bus.addr == OFS_RUN) begin
            run <= i_bus.wdata[RUN_BIT];
         end
         if (i_bus.addr == OFS_IRQ_MASK) begin
            mask <= i_bus.wdata[1:0];
         end
      end
   end

   // ==========================================================
   // Properties
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   property p_rdata_idle;
      !$past(i_bus.rd) |-> o_rdata == 8'h00;
   endproperty
   property p_count_step;
      $changed(o_count) |-> o_count == $past(o_count) + 16'h0001 || o_count == 16'h0000;
   endproperty
   property p_match_pulse;
      o_match_a |=> !o_match_a;
   endproperty
   property p_clear_on_b;
      clr && $past(clr) && o_match_b |-> o_count == 16'h0000;
   endproperty
   property p_free_run;
      !clr && !$past(clr) && o_match_b |-> o_count == $past(o_count) + 16'h0001;
   endproperty
   property p_stop_zero;
      !run && !$past(run) |-> o_count == 16'h0000 && !o_match_b;
   endproperty
   property p_irq_b;
      o_match_b && mask[IRQ_B_BIT] |=> o_irq;
   endproperty
   property p_irq_masked;
      mask == 2'h0 && $past(mask) == 2'h0 |-> !o_irq;
   endproperty
   property p_div8_gap;
      run && sel == 2'h1 && $changed(o_count) |=> ($stable(o_count) || !run) [*7];
   endproperty

   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside answer");
   a_count_step: assert property (p_count_step)
      else $error("counter jumped");
   a_match_pulse: assert property (p_match_pulse)
      else $error("match held too long");
   a_clear_on_b: assert property (p_clear_on_b)
      else $error("counter not cleared on match b");
   a_free_run: assert property (p_free_run)
      else $error("counter cleared while clearing off");
   a_stop_zero: assert property (p_stop_zero)
      else $error("stopped counter not zero");
   a_irq_b: assert property (p_irq_b)
      else $error("no interrupt after match b");
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt while masked");
   a_div8_gap: assert property (p_div8_gap)
      else $error("divide by eight ticks too close");

   c_clear: cover property (o_match_b && clr);
   c_irq: cover property (o_irq);
   c_pin: cover property ($rose(i_ext_count) && run && sel == 2'h0);
endmodule // tec_timer_asserts

bind tec_timer tec_timer_asserts i_tec_timer_asserts (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus(i_bus), .i_ext_count(i_ext_count),
   .o_rdata(o_rdata), .o_count(o_count), .o_match_a(o_match_a),
   .o_match_b(o_match_b), .o_irq(o_irq));

// file: verif/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tec_pkg::*;

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end

   logic         clk = 1'b0;
   logic         rst = 1'b1;
   tec_bus_req_t bus = '0;
   logic         pin;
   logic [7:0]   rdata;
   logic [15:0]  cnt;
   logic         ma;
   logic         mb;
   logic         irq;
   int           fails = 0;
   int           n_compared = 0;

   tec_timer i_tec_timer (.i_clk_sys(clk), .i_rst(rst), .i_bus(bus), .i_ext_count(pin),
      .o_rdata(rdata), .o_count(cnt), .o_match_a(ma), .o_match_b(mb), .o_irq(irq));
   tec_pulse_src i_tec_pulse_src (.i_clk_sys(clk), .o_pin(pin));

   initial forever #4 clk = ~clk;

   // ==========================================================
   // Bus tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus <= '0;
      #1 `CHK(rdata, exp)
   endtask
   // low byte first; the high byte commits the pair
   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask
   // Which: 0 match a, 1 match b, 2 either
   task automatic wait_m(input int w);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         #1;
         if ((w != 1 && ma) || (w != 0 && mb)) break;
      end
      if (i == 3000) fails++;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(OFS_MODE, RST_MODE);
      rd(OFS_CTRL, RST_CTRL);
      rd(OFS_RUN, RST_RUN);
      rd(OFS_CMP_A_LO, 8'h00);
      rd(8'h50, 8'h00);
      `CHK(cnt, RST_CNT)
   endtask
   task automatic t_ext;
      wr(OFS_RUN, 8'h01);
      i_tec_pulse_src.pulses(4, 2);
      i_tec_pulse_src.pulses(3, 9);
      repeat (6) @(posedge clk);
      #1 `CHK(cnt, 16'h0007)
      wr(OFS_RUN, 8'h00);
      repeat (2) @(posedge clk);
      #1 `CHK(cnt, 16'h0000)
   endtask
   task automatic t_presc;
      int          d;
      int          i;
      logic [15:0] c;
      for (int s = 1; s < 4; s++) begin
         d = 8 << (2 * s - 2);
         wr(OFS_MODE, {6'h00, 2'(s)});
         wr(OFS_RUN, 8'h01);
         // Look once the edge has settled, not in the step that moves the count
         for (i = 0; i < 300 && cnt == 16'h0000; i++) begin
            @(posedge clk);
            #1;
         end
         c = cnt;
         repeat (4 * d) @(posedge clk);
         #1 `CHK(cnt, c + 16'h0004)
         wr(OFS_RUN, 8'h00);
      end
   endtask
   task automatic t_clear;
      // Earlier scenarios leave status set; start clean so the irq check bites
      wr(OFS_IRQ_STAT, 8'h03);
      w16(OFS_CMP_A_LO, 16'h0002);
      w16(OFS_CMP_B_LO, 16'h0003);
      wr(OFS_IRQ_MASK, 8'h02);
      wr(OFS_MODE, 8'h21);
      wr(OFS_RUN, 8'h01);
      wait_m(1);
      `CHK(cnt, 16'h0000)
      @(posedge clk);
      #1 `CHK(irq, 1'b1)
      rd(OFS_IRQ_STAT, 8'h03);
      wr(OFS_IRQ_STAT, 8'h03);
      rd(OFS_IRQ_STAT, 8'h00);
      wait_m(0);
      @(posedge clk);
      #1 `CHK(irq, 1'b0)
      wr(OFS_MODE, 8'h01);
      wait_m(1);
      `CHK(cnt, 16'h0004)
      wr(OFS_RUN, 8'h00);
      wr(OFS_IRQ_STAT, 8'h03);
   endtask
   task automatic t_dbuf;
      wr(OFS_MODE, 8'h21);
      w16(OFS_CMP_B_LO, 16'h0008);
      w16(OFS_CMP_A_LO, 16'h0004);
      wr(OFS_RUN, 8'h01);
      wait_m(0);
      `CHK(cnt, 16'h0005)
      wr(OFS_CTRL, 8'h80);
      w16(OFS_CMP_A_LO, 16'h0005);
      wait_m(2);
      `CHK(mb, 1'b1)
      wait_m(0);
      `CHK(cnt, 16'h0006)
      rd(OFS_CNT_LO, 8'h06);
      rd(OFS_CNT_HI, 8'h00);
      wr(OFS_RUN, 8'h00);
      rd(OFS_CTRL, 8'h80);
   endtask

   task automatic wrap_up;
      if (fails == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_ext;
      t_presc;
      t_clear;
      t_dbuf;
      wrap_up;
   end
   // Whole run is well under two thousand cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up;
   end
endmodule // tb
